// ---- include/ocsu_pkg.sv ----
// Oscillator clock-source unit: shared constants and types.
// Assumes one 40 MHz system clock; all clock sources arrive as sampled levels.
package ocsu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses on the plain register port)
  localparam logic [7:0] OCSU_ADDR_STATUS = 8'h00;
  localparam logic [7:0] OCSU_ADDR_TRIM = 8'h01;

  // Status register fields
  localparam int OCSU_STAT_ENGAGED_BIT = 0;
  localparam int OCSU_STAT_REQUEST_BIT = 1;

  // Reset values
  localparam logic [7:0] OCSU_TRIM_RESET = 8'h80;
  localparam logic [7:0] OCSU_DATA_ZERO = 8'h00;

  // Rising edges of the external source needed before the switch
  localparam logic [1:0] OCSU_QUALIFY_EDGES = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Source select encodings
  localparam logic [1:0] OCSU_SEL_INTERNAL = 2'h0;
  localparam logic [1:0] OCSU_SEL_EXT_CLOCK = 2'h1;
  localparam logic [1:0] OCSU_SEL_EXT_RC = 2'h2;
  localparam logic [1:0] OCSU_SEL_CRYSTAL = 2'h3;

  typedef logic [1:0] ocsu_sel_t;

  // Test and monitor modes that make the switch request void
  typedef struct packed {
    logic monitor_bypass;
    logic production_test_mode;
    logic chip_test_mode;
  } ocsu_test_s;

  // Source clock levels as sampled on clk
  typedef struct packed {
    logic internal_osc_clock;
    logic ext_clock_in;
    logic rc_osc_clock;
    logic crystal_osc_clock;
  } ocsu_src_s;

  // Internal-to-external switch sequence
  typedef enum logic [2:0] {
    OCSU_IDLE,
    OCSU_QUALIFY,
    OCSU_ALIGN,
    OCSU_ENGAGE,
    OCSU_DONE
  } ocsu_switch_e;

endpackage : ocsu_pkg

// ---- hdl/ocsu_edge_qual.sv ----
// Counts rising edges of the chosen external source while armed.
// Assumes the source level is sampled synchronously on clk.
`timescale 1ns/1ps
module ocsu_edge_qual (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic arm,
  input wire logic level,
  output logic qualified
);
  import ocsu_pkg::*;

  logic prev_r;
  logic [1:0] count_r;

  // Previous level for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 2'h0;
    end else if (!arm) begin
      count_r <= 2'h0;
    end else if (level && !prev_r && count_r != OCSU_QUALIFY_EDGES) begin
      count_r <= count_r + 2'h1;
    end
  end

  assign qualified = arm && (count_r == OCSU_QUALIFY_EDGES);

endmodule : ocsu_edge_qual

// ---- hdl/ocsu_top.sv ----
// Oscillator clock-source unit: source select, clock outputs, switch logic.
// Assumes source clocks and mode inputs are synchronous to clk; the system
// integration unit divides double_rate_clock again for the bus.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module ocsu_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire ocsu_pkg::ocsu_src_s sources,
  input wire ocsu_pkg::ocsu_sel_t source_select,
  input wire ocsu_pkg::ocsu_test_s test_modes,
  input wire logic stop_mode,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic quad_rate_clock,
  output logic double_rate_clock,
  output logic internal_osc_enable,
  output logic [7:0] trim_factor
);
  import ocsu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic request_r;
  logic engaged_r;
  logic use_ext_r;
  logic int_run_r;
  logic [7:0] trim_r;
  logic [7:0] rdata_r;
  logic quad_r;
  logic double_r;
  ocsu_sel_t ext_sel_r;
  ocsu_switch_e state_r;
  ocsu_switch_e state_nxt;
  logic ext_level;
  logic src_level;
  logic ignored;
  logic qualified;
  logic wr_status;
  logic wr_trim;

  assign wr_status = reg_write && (reg_addr == OCSU_ADDR_STATUS);
  assign wr_trim = reg_write && (reg_addr == OCSU_ADDR_TRIM);

  assign ignored = test_modes.monitor_bypass
                 | test_modes.production_test_mode
                 | test_modes.chip_test_mode;

  ////////////////////////////////////////////////////////////////////////////
  // source decode
  always_comb begin
    case (ext_sel_r)
      OCSU_SEL_EXT_CLOCK: ext_level = sources.ext_clock_in;
      OCSU_SEL_EXT_RC: ext_level = sources.rc_osc_clock;
      OCSU_SEL_CRYSTAL: ext_level = sources.crystal_osc_clock;
      default: ext_level = 1'b0;
    endcase
  end

  // Active source: internal until the switch completes
  assign src_level = use_ext_r ? ext_level : sources.internal_osc_clock;

  // External source choice latched when the switch starts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sel_r <= OCSU_SEL_INTERNAL;
    end else if (state_r == OCSU_IDLE && !use_ext_r) begin
      ext_sel_r <= source_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // request bit write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      request_r <= 1'b0;
    end else if (wr_status) begin
      request_r <= reg_wdata[OCSU_STAT_REQUEST_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_r <= OCSU_TRIM_RESET;
    end else if (wr_trim) begin
      trim_r <= reg_wdata;
    end
  end

  assign trim_factor = trim_r;

  // Read data for one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= OCSU_DATA_ZERO;
    end else if (reg_read && reg_addr == OCSU_ADDR_STATUS) begin
      rdata_r <= OCSU_DATA_ZERO;
      rdata_r[OCSU_STAT_ENGAGED_BIT] <= engaged_r;
      rdata_r[OCSU_STAT_REQUEST_BIT] <= request_r;
    end else if (reg_read && reg_addr == OCSU_ADDR_TRIM) begin
      rdata_r <= trim_r;
    end else begin
      rdata_r <= OCSU_DATA_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Edge qualifier for the external source
  ocsu_edge_qual u_qual (
    .clk(clk),
    .reset_n(reset_n),
    .arm(state_r == OCSU_QUALIFY),
    .level(ext_level),
    .qualified(qualified)
  );

  // Switch sequence next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OCSU_IDLE: begin
        if (request_r && !ignored && ext_sel_r != OCSU_SEL_INTERNAL) begin
          state_nxt = OCSU_QUALIFY;
        end
      end
      OCSU_QUALIFY: begin
        if (!request_r || ignored) begin
          state_nxt = OCSU_IDLE;
        end else if (qualified) begin
          state_nxt = OCSU_ALIGN;
        end
      end
      OCSU_ALIGN: begin
        // swap only while both sources low
        if (!ext_level && !sources.internal_osc_clock) begin
          state_nxt = OCSU_ENGAGE;
        end
      end
      OCSU_ENGAGE: state_nxt = OCSU_DONE;
      OCSU_DONE: state_nxt = OCSU_DONE;
      default: state_nxt = OCSU_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= OCSU_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      use_ext_r <= 1'b0;
    end else if (state_r == OCSU_ALIGN && state_nxt == OCSU_ENGAGE) begin
      use_ext_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      engaged_r <= 1'b0;
    end else if (state_r == OCSU_ALIGN && state_nxt == OCSU_ENGAGE) begin
      engaged_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_run_r <= 1'b1;
    end else if (state_r == OCSU_ENGAGE) begin
      int_run_r <= 1'b0;
    end
  end

  assign internal_osc_enable = int_run_r && !stop_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Clock outputs; wait and break do not touch them
  // wait mode leaves clocks alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quad_r <= 1'b0;
    end else begin
      quad_r <= src_level && !stop_mode;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      double_r <= 1'b0;
    end else if (src_level && !stop_mode && !quad_r) begin
      double_r <= ~double_r;
    end
  end

  assign quad_rate_clock = quad_r;
  assign double_rate_clock = double_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_quad_internal: assert property (
    (!use_ext_r && !stop_mode) |=>
      quad_rate_clock == $past(sources.internal_osc_clock))
    else $error("quad clock does not follow internal source");

  a_double_half: assert property (
    $rose(quad_rate_clock) |-> double_rate_clock != $past(double_rate_clock))
    else $error("double clock did not toggle on quad rise");

  a_double_hold: assert property (
    !$rose(quad_rate_clock) |-> $stable(double_rate_clock))
    else $error("double clock toggled without quad rise");

  a_stop_quiet: assert property (
    stop_mode[*2] |-> !quad_rate_clock && $stable(double_rate_clock))
    else $error("clocks run in stop mode");

  a_req_ignored: assert property (
    (state_r == OCSU_IDLE && ignored) |=> state_r == OCSU_IDLE)
    else $error("switch started in test mode");

  a_engage_order: assert property (
    $rose(engaged_r) |-> int_run_r ##1 !int_run_r)
    else $error("internal stopped out of order");

  a_no_fallback: assert property (
    engaged_r |=> engaged_r && use_ext_r && !int_run_r)
    else $error("fell back from external source");

  a_trim_write: assert property (
    wr_trim |=> trim_factor == $past(reg_wdata))
    else $error("trim write lost");

  a_req_write: assert property (
    wr_status |=> request_r == $past(reg_wdata[OCSU_STAT_REQUEST_BIT]))
    else $error("request write lost");

  a_glitch_free: assert property (
    $rose(use_ext_r) |-> !quad_rate_clock && $past(qualified, 1) == 1'b0)
    else $error("switch taken on a high level");

  a_stop_osc_off: assert property (
    stop_mode |-> !internal_osc_enable)
    else $error("oscillator enabled in stop mode");

  a_status_read: assert property (
    (reg_read && reg_addr == OCSU_ADDR_STATUS) |=>
      reg_rdata[OCSU_STAT_ENGAGED_BIT] == $past(engaged_r))
    else $error("engaged bit misread");

  a_sel_held: assert property (
    (state_r != OCSU_IDLE) |=> $stable(ext_sel_r))
    else $error("source choice changed during switch");

  c_switch_done: cover property (state_r == OCSU_ALIGN ##1 engaged_r);
  c_stop_engaged: cover property (engaged_r && stop_mode);
  c_req_aborted: cover property (state_r == OCSU_QUALIFY ##1
    state_r == OCSU_IDLE);
  c_ext_qualified: cover property (qualified);
  c_req_voided: cover property (request_r && ignored);

endmodule : ocsu_top

// ---- test/ocsu_sim_model.sv ----
// System integration unit model: bus clock divider and watchdog ticks.
// Assumes the unit's clock outputs arrive as levels sampled on clk.
`timescale 1ns/1ps
module ocsu_sim_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic quad_rate_clock,
  input wire logic double_rate_clock,
  output logic bus_clock,
  output int wd_ticks
);
  logic quad_d;
  logic dbl_d;
  //////////////////////////////////////////////////////////////////////////
  // bus clock halves double
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quad_d <= 1'b0;
      dbl_d <= 1'b0;
      bus_clock <= 1'b0;
      wd_ticks <= 0;
    end else begin
      quad_d <= quad_rate_clock;
      dbl_d <= double_rate_clock;
      if (double_rate_clock && !dbl_d) begin
        bus_clock <= !bus_clock;
      end
      if (quad_rate_clock && !quad_d) begin
        wd_ticks <= wd_ticks + 1;
      end
    end
  end
endmodule : ocsu_sim_model

// ---- test/test_ocsu_top.sv ----
// Testbench of the oscillator clock-source unit with a reference model.
// Assumes the register port answers reads one cycle later.
`timescale 1ns/1ps
module test_ocsu_top;
  import ocsu_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ocsu_src_s sources = '0;
  ocsu_sel_t source_select = OCSU_SEL_INTERNAL;
  ocsu_test_s test_modes = '0;
  logic stop_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic quad_rate_clock;
  logic double_rate_clock;
  logic internal_osc_enable;
  logic [7:0] trim_factor;
  logic bus_clock;
  int wd_ticks;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int nq = 0;
  int nd = 0;
  int nr = 0;
  int nb = 0;
  logic [31:0] xs = 32'h0000_207B;
  logic chk = 1'b0;
  logic ext_on = 1'b0;
  logic q_exp = 1'b0;
  logic q_q[$];
  logic q_m = 1'b0;
  logic d_m = 1'b0;
  logic b_m = 1'b0;
  logic [7:0] v;
  logic [7:0] d;

  ocsu_top dut (.clk(clk), .reset_n(reset_n), .sources(sources),
    .source_select(source_select), .test_modes(test_modes),
    .stop_mode(stop_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .quad_rate_clock(quad_rate_clock),
    .double_rate_clock(double_rate_clock),
    .internal_osc_enable(internal_osc_enable), .trim_factor(trim_factor));
  ocsu_sim_model sim (.clk(clk), .reset_n(reset_n),
    .quad_rate_clock(quad_rate_clock),
    .double_rate_clock(double_rate_clock), .bus_clock(bus_clock),
    .wd_ticks(wd_ticks));

  //////////////////////////////////////////////////////////////////////////
  // Clock source, 25 ns period
  initial begin
    forever #12.5 clk = !clk;
  end

  function automatic logic [31:0] rnd();
    xs = xs ^ (xs << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
    return xs;
  endfunction : rnd

  function automatic logic near(int a, int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction : near

  task automatic check(logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic wr(logic [7:0] a, logic [7:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    r = reg_rdata;
  endtask : rd

  // Reference model of the quad clock, random source levels, timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      results();
    end
    // expected quad level queued for the next compare
    q_q.push_back(reset_n && !stop_mode &&
      (ext_on ? sources.ext_clock_in : sources.internal_osc_clock));
    sources <= ocsu_src_s'(4'(rnd()));
  end

  // Output checks and edge counters
  always @(negedge clk) begin
    if (q_q.size() > 0) q_exp = q_q.pop_front();
    if (!reset_n) begin
      nq = 0;
      nd = 0;
      nr = 0;
      nb = 0;
    end else begin
      if (chk) check(quad_rate_clock, q_exp);
      if (chk) check(internal_osc_enable, !stop_mode && !ext_on);
      nq += (quad_rate_clock && !q_m);
      nd += (double_rate_clock != d_m);
      nr += (double_rate_clock && !d_m);
      nb += (bus_clock != b_m);
    end
    q_m = quad_rate_clock;
    d_m = double_rate_clock;
    b_m = bus_clock;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    chk <= 1'b1;
    rd(OCSU_ADDR_TRIM, v);
    check(v, OCSU_TRIM_RESET);
    rd(OCSU_ADDR_STATUS, v);
    check(v, OCSU_DATA_ZERO);
    rd(8'h5A, v);
    check(v, OCSU_DATA_ZERO);
    for (int i = 0; i < 4; i++) begin
      d = 8'(rnd());
      wr(OCSU_ADDR_TRIM, d);
      rd(OCSU_ADDR_TRIM, v);
      check(v, d);
      check(trim_factor, d);
    end
    wr(OCSU_ADDR_STATUS, 8'h01);
    rd(OCSU_ADDR_STATUS, v);
    check(v, OCSU_DATA_ZERO);
    // Request with internal select, then under each test mode
    wr(OCSU_ADDR_STATUS, 8'h02);
    repeat (40) @(posedge clk);
    rd(OCSU_ADDR_STATUS, v);
    check(v, 8'h02);
    wr(OCSU_ADDR_STATUS, 8'h00);
    for (int i = 0; i < 3; i++) begin
      test_modes <= 3'h4 >> i;
      source_select <= ocsu_sel_t'(i + 1);
      wr(OCSU_ADDR_STATUS, 8'h02);
      repeat (40) @(posedge clk);
      rd(OCSU_ADDR_STATUS, v);
      check(v, 8'h02);
      wr(OCSU_ADDR_STATUS, 8'h00);
    end
    test_modes <= '0;
    // Stop mode holds double clock
    stop_mode <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    d = {7'h00, double_rate_clock};
    repeat (20) @(negedge clk);
    check(double_rate_clock, d[0]);
    check(quad_rate_clock, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b0;
    repeat (40) @(posedge clk);
    check(near(nq, nd), 1'b1);
    check(near(nr, nb), 1'b1);
    check(near(wd_ticks, nq), 1'b1);
    // Switch to external clock input
    source_select <= OCSU_SEL_EXT_CLOCK;
    chk <= 1'b0;
    wr(OCSU_ADDR_STATUS, 8'h02);
    v = 8'h00;
    for (int i = 0; i < 300 && v[0] !== 1'b1; i++) rd(OCSU_ADDR_STATUS, v);
    check(v, 8'h03);
    check(internal_osc_enable, 1'b0);
    ext_on <= 1'b1;
    repeat (2) @(posedge clk);
    chk <= 1'b1;
    repeat (50) @(posedge clk);
    wr(OCSU_ADDR_STATUS, 8'h00);
    repeat (20) @(posedge clk);
    rd(OCSU_ADDR_STATUS, v);
    check(v, 8'h01);
    // Second reset restarts the internal oscillator
    @(posedge clk);
    chk <= 1'b0;
    reset_n <= 1'b0;
    @(negedge clk);
    check(internal_osc_enable, 1'b1);
    @(posedge clk);
    reset_n <= 1'b1;
    ext_on <= 1'b0;
    rd(OCSU_ADDR_STATUS, v);
    check(v, OCSU_DATA_ZERO);
    check(internal_osc_enable, 1'b1);
    rd(OCSU_ADDR_TRIM, v);
    check(v, OCSU_TRIM_RESET);
    chk <= 1'b1;
    repeat (20) @(posedge clk);
    results();
  end
endmodule : test_ocsu_top
